// ---- inc/csrs_pkg.sv ----
// shared constants and types of the clock source and reset sequencer
package csrs_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDG_PULSE_NS = 20000;
  localparam int WDG_PULSE_CYC = (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_NS = 200;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_SHORT_CYC = 256;
  localparam int DLY_LONG_CYC = 4096;
  localparam int FETCH_CYC = 2;
  localparam logic [15:0] VEC_LO = 16'hfffe;
  localparam logic [15:0] VEC_HI = 16'hffff;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_RC = 2'h2
  } csrs_src_type;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_DELAY = 4'h2,
    ST_FETCH = 4'h4,
    ST_RUN = 4'h8
  } csrs_state_type;

  typedef struct packed {
    logic [1:0] lvd_lvl;
    logic lvd_en;
    logic long_dly;
    logic [1:0] xtal_rng;
    logic [1:0] src;
    logic dbl_en;
  } csrs_cfg_type;

  typedef struct packed {
    logic pin_lvl;
    logic [3:0] state;
    logic wdg_flag;
    logic low_supply_reset_flag;
  } csrs_stat_type;

  localparam csrs_cfg_type CFG_RST = '{lvd_lvl: 2'h1, lvd_en: 1'b1, long_dly: 1'b0,
                                       xtal_rng: 2'h0, src: SRC_EXT, dbl_en: 1'b0};

endpackage

// ---- verilog/csrs_rst_sync.sv ----
// reset request catcher: asserts at once, releases on the clock
module csrs_rst_sync (
  input wire logic mclk,
  input wire logic async_n,
  output logic req
);
  logic [1:0] sync_q;

  always_ff @(posedge mclk or negedge async_n) begin
    if (!async_n) begin
      sync_q <= 2'h3;
    end else begin
      sync_q <= {sync_q[0], 1'b0};
    end
  end

  assign req = sync_q[1];
endmodule // csrs_rst_sync

// ---- verilog/csrs_filt.sv ----
// pin synchroniser with stability filter
module csrs_filt #(
  parameter int N = 5
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(N + 1);
  logic [1:0] sync_q;
  logic [CW-1:0] cnt_q;
  logic out_q;

  if (N < 1) begin : g_chk
    $error("csrs_filt: N must be at least one");
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 2'h0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], din};
      if (sync_q[1] == out_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(N - 1)) begin
        cnt_q <= '0;
        out_q <= sync_q[1];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign dout = out_q;
endmodule // csrs_filt

// ---- verilog/csrs_top.sv ----
// clock source selection and reset sequencer with ahb-lite registers
//
// How it works
// - doubler on, external or crystal source: one core tick on each oscillator edge, twice the rate
// - doubler off: core tick on every second rising oscillator edge
// - source is external clock, one of four crystal ranges, or rc oscillator
// - crystal amplifier enable follows configuration, not reset state
// - pin, supply drop and watchdog all start the reset sequence
// - reset pin is driven low throughout the delay phase
// - vector fetch presents addresses fffe then ffff
// - active phase, then 256 or 4096 core cycles delay, then fetch
// - vector fetch lasts exactly two core cycles
// - reset pin is both input and open-drain output
// - low reset pin is caught asynchronously, even without clock
// - supply drop drives the reset pin low
// - supply drop input is spike filtered
// - watchdog underflow drives pin low for a minimum pulse width
// - detector threshold is low, medium or high by configuration
// - supply drop reset sets a flag, cleared by writing zero
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
module csrs_top
  import csrs_pkg::*;
#(
  parameter int DLY_SHORT = csrs_pkg::DLY_SHORT_CYC,
  parameter int DLY_LONG = csrs_pkg::DLY_LONG_CYC,
  parameter int WDG_CYC = csrs_pkg::WDG_PULSE_CYC,
  parameter int FILT_CYC = csrs_pkg::SPIKE_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clock_in_pin,
  input wire logic rc_osc_in,
  output logic xtal_en,
  output logic [1:0] xtal_range,
  output logic rc_en,
  output logic core_tick,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  input wire logic supply_low,
  output logic [1:0] lvd_level,
  output logic lvd_en,
  input wire logic wdg_underflow,
  output logic core_rst_n,
  output logic vec_fetch,
  output logic [15:0] vec_addr
);
  import csrs_pkg::*;

  localparam int DW = $clog2(DLY_LONG + 1);
  localparam int WW = $clog2(WDG_CYC + 1);

  if (DLY_SHORT < 1 || DLY_LONG < DLY_SHORT) begin : g_chk_dly
    $error("csrs_top: delay counts must be positive and ordered");
  end
  if (WDG_CYC < 1 || FILT_CYC < 1) begin : g_chk_wdg
    $error("csrs_top: pulse and filter counts must be positive");
  end

  // ************************************************************
  // ahb-lite register slave
  // ************************************************************
  csrs_cfg_type cfg_q;
  csrs_stat_type stat;
  logic lsr_flag_q;
  logic wdg_flag_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_stat;
  logic [31:0] rd_mux;

  assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  assign wr_ctrl = wr_pend_q && wr_addr_q == CTRL_OFS;
  assign wr_stat = wr_pend_q && wr_addr_q == STAT_OFS;
  assign rd_mux = (haddr[7:0] == CTRL_OFS) ? 32'(cfg_q) :
                  (haddr[7:0] == STAT_OFS) ? 32'(stat) : 32'h0000_0000;
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RST;
    end else if (wr_ctrl) begin
      cfg_q <= csrs_cfg_type'(hwdata[$bits(csrs_cfg_type)-1:0]);
    end
  end

  // ************************************************************
  // oscillator selection and core tick
  // ************************************************************
  logic src_xtal;
  logic src_rc;
  logic osc_raw;
  logic [2:0] osc_q;
  logic osc_rise;
  logic osc_fall;
  logic dbl_on;
  logic div_q;
  logic tick_q;

  assign src_xtal = cfg_q.src == SRC_XTAL;
  assign src_rc = cfg_q.src == SRC_RC;
  assign osc_raw = src_rc ? rc_osc_in : clock_in_pin;
  assign xtal_en = src_xtal;
  assign xtal_range = cfg_q.xtal_rng;
  assign rc_en = src_rc;
  assign dbl_on = cfg_q.dbl_en && !src_rc;
  assign osc_rise = osc_q[1] && !osc_q[2];
  assign osc_fall = !osc_q[1] && osc_q[2];
  assign core_tick = tick_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_q <= 3'h0;
      div_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      osc_q <= {osc_q[1:0], osc_raw};
      if (osc_rise) begin
        div_q <= !div_q;
      end
      tick_q <= dbl_on ? (osc_rise || osc_fall) : (osc_rise && div_q);
    end
  end

  // ************************************************************
  // reset sources
  // ************************************************************
  logic ext_async_n;
  logic ext_req;
  logic lvd_filt;
  logic lvd_req;
  logic [WW-1:0] wdg_cnt_q;
  logic wdg_req;
  logic any_src;
  logic [1:0] pin_sync_q;
  logic pin_mask_q;

  // own drive masked, one cycle past release
  assign ext_async_n = arst_n && (rst_pin_i || pin_mask_q);

  csrs_rst_sync u_ext_sync (
    .mclk(mclk),
    .async_n(ext_async_n),
    .req(ext_req)
  );

  csrs_filt #(
    .N(FILT_CYC)
  ) u_lvd_filt (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(supply_low),
    .dout(lvd_filt)
  );

  assign lvd_level = cfg_q.lvd_lvl;
  assign lvd_en = cfg_q.lvd_en;
  assign lvd_req = cfg_q.lvd_en && lvd_filt;
  assign wdg_req = wdg_underflow || wdg_cnt_q != '0;
  assign any_src = ext_req || lvd_req || wdg_req;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdg_cnt_q <= '0;
    end else if (wdg_underflow) begin
      wdg_cnt_q <= WW'(WDG_CYC);
    end else if (wdg_req) begin
      wdg_cnt_q <= wdg_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], rst_pin_i};
    end
  end

  // ************************************************************
  // reset sequencer
  // ************************************************************
  csrs_state_type state_q;
  csrs_state_type state_d;
  logic [DW-1:0] dly_cnt_q;
  logic [DW-1:0] dly_last;
  logic fcnt_q;
  logic drive_d;
  logic oe_q;
  logic [15:0] vec_q;
  logic fetch_q;

  assign dly_last = cfg_q.long_dly ? DW'(DLY_LONG - 1) : DW'(DLY_SHORT - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (!any_src) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (any_src) begin
          state_d = ST_ACTIVE;
        end else if (tick_q && dly_cnt_q == dly_last) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (any_src) begin
          state_d = ST_ACTIVE;
        end else if (tick_q && fcnt_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  assign drive_d = lvd_req || wdg_req || state_d == ST_DELAY;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = oe_q;
  assign core_rst_n = state_q == ST_RUN;
  assign vec_fetch = fetch_q;
  assign vec_addr = vec_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_ACTIVE;
      oe_q <= 1'b1;
      pin_mask_q <= 1'b1;
    end else begin
      state_q <= state_d;
      oe_q <= drive_d;
      // mask outlives the drive so a rising pin is no false catch
      pin_mask_q <= drive_d || oe_q;
    end
  end

  // delay count, restarted by any source
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dly_cnt_q <= '0;
    end else if (state_q != ST_DELAY || any_src) begin
      dly_cnt_q <= '0;
    end else if (tick_q) begin
      dly_cnt_q <= dly_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fcnt_q <= 1'b0;
      fetch_q <= 1'b0;
      vec_q <= VEC_LO;
    end else begin
      fetch_q <= state_q == ST_FETCH && tick_q && !any_src;
      if (state_q != ST_FETCH) begin
        fcnt_q <= 1'b0;
      end else if (tick_q) begin
        fcnt_q <= 1'b1;
      end
      if (state_q == ST_FETCH && tick_q) begin
        vec_q <= fcnt_q ? VEC_HI : VEC_LO;
      end
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  assign stat = '{pin_lvl: pin_sync_q[1], state: state_q, wdg_flag: wdg_flag_q,
                  low_supply_reset_flag: lsr_flag_q};

  // set wins over write of zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lsr_flag_q <= 1'b0;
      wdg_flag_q <= 1'b0;
    end else begin
      if (lvd_req) begin
        lsr_flag_q <= 1'b1;
      end else if (wr_stat && !hwdata[0]) begin
        lsr_flag_q <= 1'b0;
      end
      if (wdg_underflow) begin
        wdg_flag_q <= 1'b1;
      end else if (wr_stat && !hwdata[1]) begin
        wdg_flag_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_delay_drive;
    state_q == ST_DELAY |-> rst_pin_oe;
  endproperty
  a_delay_drive: assert property (p_delay_drive) else $error("pin not driven in delay");

  property p_fetch_len;
    state_q == ST_FETCH && tick_q && fcnt_q && !any_src |=> state_q == ST_RUN;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch not ended after two");

  property p_run_entry;
    $rose(core_rst_n) |-> $past(state_q == ST_FETCH && fcnt_q && tick_q);
  endproperty
  a_run_entry: assert property (p_run_entry) else $error("run entered early");

  property p_dly_done;
    $rose(state_q == ST_FETCH) |-> $past(dly_cnt_q == dly_last && tick_q);
  endproperty
  a_dly_done: assert property (p_dly_done) else $error("delay cut short");

  property p_restart;
    any_src |=> state_q == ST_ACTIVE && dly_cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");

  property p_wdg_pulse;
    wdg_underflow |=> wdg_cnt_q == WW'(WDG_CYC) && rst_pin_oe;
  endproperty
  a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog pulse missing");

  property p_lvd_drive;
    lvd_req |=> rst_pin_oe && lsr_flag_q;
  endproperty
  a_lvd_drive: assert property (p_lvd_drive) else $error("supply drop not handled");

  property p_half_rate;
    !dbl_on && osc_rise |=> tick_q == !div_q;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("divide by two broken");

  property p_vec_addr;
    fetch_q && $past(fcnt_q) |-> vec_addr == VEC_HI;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("wrong second vector");

  property p_ext_catch;
    !rst_pin_i && !pin_mask_q |-> ext_req;
  endproperty
  a_ext_catch: assert property (p_ext_catch) else $error("pin reset missed");

  c_run: cover property ($rose(core_rst_n));
  c_wdg: cover property (wdg_underflow ##1 state_q == ST_ACTIVE);
  c_lvd: cover property (lvd_req && state_q == ST_RUN);
  c_restart: cover property (state_q == ST_DELAY && dly_cnt_q != '0 ##1 state_q == ST_ACTIVE);

endmodule // csrs_top

// ---- verification/csrs_rst_line.sv ----
// model of the outside reset circuitry sharing the open-drain reset line
module csrs_rst_line (
  input wire logic mclk,
  input wire logic pull_start,
  input wire logic [7:0] pull_len,
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold_q = 8'h00;
  always @(posedge mclk) begin
    if (pull_start) begin
      hold_q <= pull_len;
    end else if (hold_q != 8'h00) begin
      hold_q <= hold_q - 8'h01;
    end
  end
  assign pin_lvl = ~((dev_oe & ~dev_o) | (hold_q != 8'h00));
endmodule // csrs_rst_line

// ---- verification/csrs_top_bench.sv ----
// self-checking testbench of the clock source and reset sequencer
module csrs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csrs_pkg::*;
  localparam int DS = 4;
  localparam int DL = 8;
  localparam int WC = 4;
  localparam logic [31:0] CTL [6] = '{32'h0c0, 32'h0c1, 32'h0c2, 32'h0c4, 32'h0c3, 32'h0c6};
  localparam int NT [6] = '{6, 24, 6, 8, 24, 6};
  // **********
  // signals and design
  // **********
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic clock_in_pin = 1'b0;
  logic rc_osc_in = 1'b0;
  logic supply_low = 1'b0;
  logic wdg_underflow = 1'b0;
  logic pull_start = 1'b0;
  logic [7:0] pull_len = 8'h00;
  logic [3:0] osc_cnt = 4'h0;
  logic [1:0] rc_cnt = 2'h0;
  logic rd_ph = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, xtal_en, rc_en, core_tick, rst_pin_i, rst_pin_o, rst_pin_oe;
  logic lvd_en, core_rst_n, vec_fetch;
  logic [1:0] xtal_range, lvd_level;
  logic [15:0] vec_addr;
  logic [31:0] q_rd[$];
  logic [15:0] q_vec[$];
  int n_checks = 0;
  int n_mismatch = 0;

  csrs_top #(.DLY_SHORT(DS), .DLY_LONG(DL), .WDG_CYC(WC), .FILT_CYC(2)) uut (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clock_in_pin(clock_in_pin), .rc_osc_in(rc_osc_in),
    .xtal_en(xtal_en), .xtal_range(xtal_range), .rc_en(rc_en), .core_tick(core_tick),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .supply_low(supply_low), .lvd_level(lvd_level), .lvd_en(lvd_en),
    .wdg_underflow(wdg_underflow), .core_rst_n(core_rst_n), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr));

  csrs_rst_line line (.mclk(mclk), .pull_start(pull_start), .pull_len(pull_len),
    .dev_o(rst_pin_o), .dev_oe(rst_pin_oe), .pin_lvl(rst_pin_i));

  always #20 mclk = ~mclk;

  // oscillators: external period 8, rc period 6 clock cycles
  always @(posedge mclk) begin
    osc_cnt <= osc_cnt + 4'h1;
    clock_in_pin <= osc_cnt[2];
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    if (rc_cnt == 2'h2) begin
      rc_osc_in <= ~rc_osc_in;
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_true(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  always @(posedge mclk) begin
    if (rd_ph) begin
      chk_word(hrdata, q_rd.pop_front(), "read data");
      chk_true(hresp === 1'b0, "okay response");
    end
  end

  always @(negedge mclk) begin
    if (vec_fetch === 1'b1) begin
      chk_word({16'h0, vec_addr}, {16'h0, q_vec.pop_front()}, "vector address");
    end
  end

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= ~w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q_rd.push_back(exp);
    ahb(a, 1'b0, 32'h0);
  endtask

  function automatic logic [31:0] stat(input logic lf, input logic wf);
    csrs_stat_type s;
    s = '{pin_lvl: 1'b1, state: 4'h8, wdg_flag: wf, low_supply_reset_flag: lf};
    return {25'h0, s};
  endfunction

  task automatic run_seq(input int dly, input string name);
    int nt;
    int nf;
    int g;
    nt = 0;
    nf = 0;
    q_vec.push_back(VEC_LO);
    q_vec.push_back(VEC_HI);
    for (g = 0; g < 20 && core_rst_n !== 1'b0; g++) begin
      @(negedge mclk);
    end
    for (g = 0; g < 4000 && !(core_rst_n === 1'b1 && nt > 0); g++) begin
      @(negedge mclk);
      nt += (core_tick === 1'b1);
      nf += (vec_fetch === 1'b1);
      if (nt >= 2 && nt < dly) chk_true(rst_pin_oe === 1'b1, "pin driven in delay");
    end
    @(negedge mclk);
    chk_true(nt >= dly + 2 && nt <= dly + 3, "ticks in reset");
    chk_true(nf == 2 && q_vec.size() == 0, "two vector fetches");
    $display("test %s done", name);
    @(posedge mclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish;
  end

  // **********
  // tests
  // **********
  initial begin
    logic [31:0] v;
    csrs_cfg_type c;
    int i;
    int n;
    void'($urandom(77));
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    run_seq(DS, "power-up");
    rd(CTRL_OFS, 32'h0c0);
    rd(STAT_OFS, stat(1'b0, 1'b0));
    ahb(8'h08, 1'b1, 32'hffffffff);
    rd(8'h08, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = $urandom & 32'h1ff;
      if (v[2:1] == 2'h2) v[0] = 1'b0;
      c = csrs_cfg_type'(v[8:0]);
      ahb(CTRL_OFS, 1'b1, v);
      @(negedge mclk);
      chk_word({25'h0, xtal_en, rc_en, xtal_range, lvd_level, lvd_en}, {25'h0,
        c.src == SRC_XTAL, c.src == SRC_RC, c.xtal_rng, c.lvd_lvl, c.lvd_en}, "config");
      @(posedge mclk);
      rd(CTRL_OFS, v);
    end
    $display("test registers done");
    for (i = 0; i < 6; i++) begin
      ahb(CTRL_OFS, 1'b1, CTL[i]);
      repeat (8) @(posedge mclk);
      n = 0;
      repeat (96) begin
        @(negedge mclk);
        n += (core_tick === 1'b1);
      end
      chk_true(n >= NT[i] - 1 && n <= NT[i] + 1, "core tick rate");
      @(posedge mclk);
    end
    $display("test clock sources done");
    ahb(CTRL_OFS, 1'b1, 32'h0e0);
    pull_len <= 8'h03;
    pull_start <= 1'b1;
    @(posedge mclk);
    pull_start <= 1'b0;
    run_seq(DL, "pin reset");
    supply_low <= 1'b1;
    @(posedge mclk);
    supply_low <= 1'b0;
    repeat (10) @(negedge mclk);
    chk_true(core_rst_n === 1'b1, "spike ignored");
    @(posedge mclk);
    supply_low <= 1'b1;
    repeat (12) @(negedge mclk);
    chk_true(rst_pin_oe === 1'b1 && rst_pin_i === 1'b0, "supply drop drives pin");
    @(posedge mclk);
    supply_low <= 1'b0;
    run_seq(DL, "supply drop");
    rd(STAT_OFS, stat(1'b1, 1'b0));
    ahb(STAT_OFS, 1'b1, 32'h0);
    rd(STAT_OFS, stat(1'b0, 1'b0));
    wdg_underflow <= 1'b1;
    @(posedge mclk);
    wdg_underflow <= 1'b0;
    repeat (WC + 1) @(negedge mclk);
    chk_true(rst_pin_oe === 1'b1, "watchdog pulse");
    repeat (40) @(posedge mclk);
    wdg_underflow <= 1'b1;
    @(posedge mclk);
    wdg_underflow <= 1'b0;
    run_seq(DL, "watchdog restart");
    rd(STAT_OFS, stat(1'b0, 1'b1));
    tally_and_finish;
  end
endmodule // csrs_top_bench
